// ### design/smc_mode_ctrl.sv
/*
 * mode and reference control of a network timing synchronizer:
 * frame timing, control state machine, holdover store and apb registers.
 * assumes loss inputs and dpll status synchronous to mclk.
 */
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module smc_mode_ctrl
   import smc_pkg::*;
#(
   parameter int P_FRAME_CYC = FRAME_CYC,
   parameter int P_LOCK_FRAMES = LOCK_FRAMES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // apb slave
   input wire smc_apb_req_t apb_req,
   output smc_apb_rsp_t apb_rsp,
   // loss detectors
   input wire logic primary_loss_input,
   input wire logic secondary_loss_input,
   // dpll status
   input wire logic dpll_lock,
   input wire logic [31:0] dpll_freq_word,
   // dpll control and frame pulse
   output smc_dpll_ctl_t dpll_ctl,
   output logic frame_pulse_8k_output
);
   typedef struct packed {
      smc_apb_rsp_t rsp;
      smc_dpll_ctl_t ctl;
      logic fp;
      logic [13:0] fcnt;
      smc_state_t st;
      logic [5:0] ctrl;
      logic started;
      logic [7:0] save_cnt;
      logic wsel;
      logic [31:0] slot0;
      logic [31:0] slot1;
      logic [17:0] lock_cnt;
      logic lock_late;
      logic [31:0] tie_cnt;
   } smc_regs_t;

   smc_regs_t s_r;
   smc_regs_t s_nxt;

   // next state of the whole block
   always_comb begin
      logic [1:0] ms;
      logic reference_select;
      logic gt;
      logic tick;
      logic tie;
      logic normal;
      smc_state_t nx;
      logic [31:0] rd;
      logic hit;
      s_nxt = s_r;
      ms = {s_r.ctrl[MSH_BIT], s_r.ctrl[MSL_BIT]};
      reference_select = s_r.ctrl[REFERENCE_SELECT_BIT];
      gt = s_r.ctrl[GT_BIT];
      tick = (s_r.fcnt == 14'h0000);
      tie = 1'b0;
      nx = s_r.st;
      rd = 32'h0000_0000;
      hit = 1'b1;
      normal = (s_r.st == state_primary_normal) ||
               (s_r.st == state_secondary_normal);

      // frame timer; the pulse rises one cycle after the count wraps
      s_nxt.fp = tick;
      if (s_r.fcnt == 14'(P_FRAME_CYC - 1)) begin
         s_nxt.fcnt = 14'h0000;
      end else begin
         s_nxt.fcnt = s_r.fcnt + 14'h0001;
      end

      // state decisions from the current inputs
      if (ms == MS_AUTO) begin
         if (reference_select) begin
            nx = s_r.st; // reserved reference select holds
         end else if (!s_r.started) begin
            if (primary_loss_input && secondary_loss_input) begin
               nx = state_freerun;
            end
         end else if (!primary_loss_input) begin
            nx = state_primary_normal;
            case (s_r.st)
               state_secondary_normal: tie = 1'b1;
               state_secondary_holdover: tie = 1'b1;
               state_primary_holdover: tie = gt;
               default: tie = 1'b0;
            endcase
         end else if (!secondary_loss_input) begin
            case (s_r.st)
               state_freerun: begin
                  nx = gt ? state_secondary_normal : state_primary_normal;
               end
               state_primary_normal: begin
                  nx = gt ? state_secondary_normal : state_primary_holdover;
                  tie = gt;
               end
               state_primary_holdover: begin
                  if (gt) begin
                     nx = state_secondary_normal;
                     tie = 1'b1;
                  end
               end
               state_secondary_holdover: begin
                  nx = state_secondary_normal;
                  tie = 1'b1;
               end
               default: nx = s_r.st;
            endcase
         end else begin
            case (s_r.st)
               state_primary_normal: nx = state_primary_holdover;
               state_secondary_normal: nx = state_secondary_holdover;
               default: nx = s_r.st;
            endcase
         end
      end else begin
         case (ms)
            MS_NORMAL: begin
               if (!reference_select) begin
                  nx = state_primary_normal;
                  case (s_r.st)
                     state_secondary_normal: tie = 1'b1;
                     state_secondary_holdover: tie = 1'b1;
                     state_primary_holdover: tie = gt;
                     default: tie = 1'b0;
                  endcase
               end else begin
                  nx = state_secondary_normal;
                  tie = (s_r.st != state_freerun) &&
                        (s_r.st != state_secondary_normal);
               end
            end
            MS_HOLD: begin
               // unlisted entries leave the state alone
               if (!reference_select) begin
                  if (s_r.st == state_primary_normal) begin
                     nx = state_primary_holdover;
                  end else begin
                     nx = s_r.st;
                  end
               end else begin
                  if (s_r.st == state_primary_normal ||
                      s_r.st == state_secondary_normal) begin
                     nx = state_secondary_holdover;
                  end else begin
                     nx = s_r.st;
                  end
               end
            end
            MS_FREE: nx = state_freerun;
            default: nx = s_r.st;
         endcase
      end

      // state changes only on the frame tick
      s_nxt.ctl.tie_correct = 1'b0;
      if (tick) begin
         s_nxt.st = nx;
         s_nxt.started = 1'b1;
         s_nxt.ctl.tie_correct = tie && (nx != s_r.st);
         if (tie && (nx != s_r.st)) begin
            s_nxt.tie_cnt = s_r.tie_cnt + 32'h0000_0001;
         end
         // entering holdover takes the older saved word
         if ((nx == state_primary_holdover || nx == state_secondary_holdover) &&
             s_r.st != state_primary_holdover &&
             s_r.st != state_secondary_holdover) begin
            s_nxt.ctl.hold_word = s_r.wsel ? s_r.slot1 : s_r.slot0;
         end
      end

      // dpll steering from the registered state
      case (s_r.st)
         state_freerun: begin
            s_nxt.ctl.dpll_mode = DM_FREE;
            s_nxt.ctl.ref_use = 1'b0;
         end
         state_primary_normal, state_secondary_normal: begin
            s_nxt.ctl.dpll_mode = DM_NORMAL;
            s_nxt.ctl.ref_use = 1'b1;
         end
         default: begin
            s_nxt.ctl.dpll_mode = DM_HOLD;
            s_nxt.ctl.ref_use = 1'b0;
         end
      endcase
      s_nxt.ctl.ref_sel = (s_r.st == state_secondary_normal) ||
                          (s_r.st == state_secondary_holdover);
      s_nxt.ctl.freq_sel = {s_r.ctrl[FSH_BIT], s_r.ctrl[FSL_BIT]};

      // frequency word saved every 30 ms while locked in normal mode
      if (tick) begin
         if (normal && dpll_lock) begin
            if (s_r.save_cnt == 8'(SAVE_FRAMES - 1)) begin
               s_nxt.save_cnt = 8'h00;
               s_nxt.wsel = ~s_r.wsel;
               if (s_r.wsel) begin
                  s_nxt.slot1 = dpll_freq_word;
               end else begin
                  s_nxt.slot0 = dpll_freq_word;
               end
            end else begin
               s_nxt.save_cnt = s_r.save_cnt + 8'h01;
            end
         end else begin
            s_nxt.save_cnt = 8'h00;
         end
      end

      // lock watchdog in frames while normal and unlocked
      if (tick) begin
         if (!normal || dpll_lock) begin
            s_nxt.lock_cnt = 18'h00000;
         end else if (s_r.lock_cnt == 18'(P_LOCK_FRAMES - 1)) begin
            s_nxt.lock_late = 1'b1;
         end else begin
            s_nxt.lock_cnt = s_r.lock_cnt + 18'h00001;
         end
      end

      // apb read mux
      case (apb_req.paddr)
         CTRL_OFS: rd = {26'h0000000, s_r.ctrl};
         STAT_OFS: rd = {25'h0000000, s_r.wsel, s_r.lock_late, dpll_lock,
                         1'b0, s_r.st};
         HOLD_OFS: rd = s_r.ctl.hold_word;
         TIEC_OFS: rd = s_r.tie_cnt;
         default: hit = 1'b0;
      endcase

      // apb: one wait state, write lands at the completing edge
      s_nxt.rsp.pready = 1'b0;
      if (apb_req.psel && apb_req.penable && !s_r.rsp.pready) begin
         s_nxt.rsp.pready = 1'b1;
         s_nxt.rsp.pslverr = !hit;
         s_nxt.rsp.prdata = (apb_req.pwrite || !hit) ? 32'h0000_0000 : rd;
      end
      if (apb_req.psel && apb_req.penable && s_r.rsp.pready) begin
         s_nxt.rsp.pslverr = 1'b0;
         s_nxt.rsp.prdata = 32'h0000_0000;
         if (apb_req.pwrite && apb_req.paddr == CTRL_OFS) begin
            s_nxt.ctrl = apb_req.pwdata[5:0];
         end
      end
   end

   // single state register
   always_ff @(posedge mclk) begin
      if (srst) begin
         s_r <= '0;
         s_r.ctrl <= CTRL_RST;
         s_r.st <= state_freerun;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from flops
   assign apb_rsp = s_r.rsp;
   assign dpll_ctl = s_r.ctl;
   assign frame_pulse_8k_output = s_r.fp;
endmodule

// ### design/smc_pkg.sv
/*
 * constants, types and state encoding for the synchronizer mode control.
 * assumes a 125 MHz mclk and an apb master with 32-bit data.
 */
package smc_pkg;
   localparam int MCLK_HZ = 125_000_000;
   localparam int FRAME_HZ = 8000;
   localparam int FRAME_CYC = MCLK_HZ / FRAME_HZ;
   localparam int SAVE_MS = 30;
   localparam int SAVE_FRAMES = SAVE_MS * FRAME_HZ / 1000;
   localparam int LOCK_S = 25;
   localparam int LOCK_FRAMES = LOCK_S * FRAME_HZ;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] HOLD_OFS = 8'h08;
   localparam logic [7:0] TIEC_OFS = 8'h0c;
   // control field positions
   localparam int MSL_BIT = 0;
   localparam int MSH_BIT = 1;
   localparam int REFERENCE_SELECT_BIT = 2;
   localparam int GT_BIT = 3;
   localparam int FSL_BIT = 4;
   localparam int FSH_BIT = 5;
   localparam logic [5:0] CTRL_RST = 6'h03;
   // mode select codes
   localparam logic [1:0] MS_NORMAL = 2'h0;
   localparam logic [1:0] MS_HOLD = 2'h1;
   localparam logic [1:0] MS_FREE = 2'h2;
   localparam logic [1:0] MS_AUTO = 2'h3;
   // dpll mode codes
   localparam logic [1:0] DM_FREE = 2'h0;
   localparam logic [1:0] DM_NORMAL = 2'h1;
   localparam logic [1:0] DM_HOLD = 2'h2;
   typedef enum logic [2:0] {
      state_freerun,
      state_primary_normal,
      state_secondary_normal,
      state_primary_holdover,
      state_secondary_holdover
   } smc_state_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } smc_apb_req_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } smc_apb_rsp_t;
   typedef struct packed {
      logic ref_sel;
      logic ref_use;
      logic [1:0] dpll_mode;
      logic [1:0] freq_sel;
      logic tie_correct;
      logic [31:0] hold_word;
   } smc_dpll_ctl_t;
endpackage

// ### verification/smc_mode_ctrl_properties.sv
/* concurrent checks on the mode control ports.
   bound to smc_mode_ctrl from the testbench; one clock domain. */
`timescale 1ns/1ps
module smc_mode_ctrl_chk
   import smc_pkg::*;
#(
   parameter int P_FRAME_CYC = FRAME_CYC,
   parameter int P_LOCK_FRAMES = LOCK_FRAMES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // apb
   input wire smc_apb_req_t apb_req,
   input wire smc_apb_rsp_t apb_rsp,
   // dpll side
   input wire smc_dpll_ctl_t dpll_ctl,
   input wire logic frame_pulse_8k_output
);
   logic seen_r;
   logic [31:0] gap_r;
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // cycles since the last frame pulse
   always_ff @(posedge mclk) begin
      seen_r <= !srst && (seen_r || frame_pulse_8k_output);
      gap_r <= (srst || frame_pulse_8k_output) ? 32'h1 : gap_r + 32'h1;
   end
   sequence acc_start;
      apb_req.psel && apb_req.penable && !$past(apb_req.penable);
   endsequence
   sequence rdy_pulse;
      apb_rsp.pready ##1 !apb_rsp.pready;
   endsequence
   sequence tie_pulse;
      dpll_ctl.tie_correct ##1 !dpll_ctl.tie_correct;
   endsequence
   fp_gap_a: assert property (
      frame_pulse_8k_output && seen_r |-> gap_r == P_FRAME_CYC)
      else $error("frame pulse spacing wrong");
   fp_single_a: assert property (
      frame_pulse_8k_output |=> !frame_pulse_8k_output) else $error("frame pulse too long");
   apb_answer_a: assert property (
      acc_start |-> ##1 rdy_pulse) else $error("apb answer late or long");
   rsp_idle_a: assert property (
      !apb_rsp.pready |-> apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr)
      else $error("response outside pready");
   tie_tick_a: assert property (
      dpll_ctl.tie_correct |-> frame_pulse_8k_output ##0 tie_pulse)
      else $error("correction pulse off the tick");
   mode_tick_a: assert property (
      $changed(dpll_ctl.dpll_mode) || $changed(dpll_ctl.ref_sel) |-> $past(frame_pulse_8k_output))
      else $error("mode changed off the tick");
   ref_use_a: assert property (
      dpll_ctl.ref_use |-> dpll_ctl.dpll_mode == DM_NORMAL) else $error("reference used off normal");
   hold_no_tie_a: assert property (
      dpll_ctl.tie_correct |=> dpll_ctl.dpll_mode == DM_NORMAL)
      else $error("correction not into normal");
   hold_word_a: assert property (
      $changed(dpll_ctl.hold_word) |-> dpll_ctl.dpll_mode != DM_HOLD ##1
      dpll_ctl.dpll_mode == DM_HOLD) else $error("hold word moved outside entry");
endmodule

// ### verification/smc_far_end.sv
/* far side model: loss detectors and dpll status.
   commands come from the testbench; lock follows ref_use. */
`timescale 1ns/1ps
module smc_far_end (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // bench commands
   input wire logic pri_cmd,
   input wire logic sec_cmd,
   input wire logic [31:0] word_cmd,
   input wire logic [31:0] lock_dly,
   input wire logic ref_use,
   // status toward the block
   output logic primary_loss_input,
   output logic secondary_loss_input,
   output logic dpll_lock,
   output logic [31:0] dpll_freq_word
);
   logic [31:0] cnt_r;
   // detectors report one cycle after the command
   always_ff @(posedge mclk) begin
      primary_loss_input <= pri_cmd;
      secondary_loss_input <= sec_cmd;
      dpll_freq_word <= word_cmd;
   end
   // lock only once the reference has been used lock_dly cycles
   always_ff @(posedge mclk) begin
      if (srst || !ref_use) begin
         cnt_r <= '0;
         dpll_lock <= 1'b0;
      end else if (cnt_r == lock_dly) begin
         dpll_lock <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h1;
      end
   end
endmodule

// ### verification/testbench.sv
/* self-checking bench for smc_mode_ctrl over apb.
   assumes the far end model and the bound checker. */
`timescale 1ns/1ps
bind smc_mode_ctrl smc_mode_ctrl_chk #(.P_FRAME_CYC(P_FRAME_CYC),
   .P_LOCK_FRAMES(P_LOCK_FRAMES)) i_smc_mode_ctrl_chk (.mclk(mclk), .srst(srst),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .dpll_ctl(dpll_ctl),
   .frame_pulse_8k_output(frame_pulse_8k_output));
module testbench;
   import smc_pkg::*;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} smc_note_t;
   // ctrl, losses {pri,sec}, state, correction
   localparam logic [9:0] STEPS [20] = '{10'h0f0, 10'h0c2, 10'h0e6, 10'h2c3, 10'h2e5,
      10'h0f8, 10'h048, 10'h105, 10'h148, 10'h003, 10'h046, 10'h002, 10'h080, 10'h140,
      10'h1c0, 10'h104, 10'h044, 10'h003, 10'h046, 10'h203};
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic pri_cmd = 1'b1;
   logic sec_cmd = 1'b1;
   logic [31:0] word_cmd = '0;
   logic [31:0] lock_dly = 32'd20;
   smc_apb_req_t apb_req = '0;
   smc_apb_rsp_t apb_rsp;
   smc_dpll_ctl_t dpll_ctl;
   logic pri_loss, sec_loss, lock, fp;
   logic [31:0] fword, word_a;
   int bad_count = 0;
   int n_tests = 0;
   int tiec = 0;
   smc_note_t notes[$];
   smc_mode_ctrl #(.P_FRAME_CYC(16), .P_LOCK_FRAMES(4)) i_smc_mode_ctrl (.mclk(mclk),
      .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp), .primary_loss_input(pri_loss),
      .secondary_loss_input(sec_loss), .dpll_lock(lock), .dpll_freq_word(fword),
      .dpll_ctl(dpll_ctl), .frame_pulse_8k_output(fp));
   smc_far_end i_smc_far_end (.mclk(mclk), .srst(srst), .pri_cmd(pri_cmd), .sec_cmd(sec_cmd),
      .word_cmd(word_cmd), .lock_dly(lock_dly), .ref_use(dpll_ctl.ref_use),
      .primary_loss_input(pri_loss), .secondary_loss_input(sec_loss), .dpll_lock(lock),
      .dpll_freq_word(fword));
   // 125 mhz clock
   initial forever #4 mclk = ~mclk;
   // one apb transfer; the expected answer is queued first
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
      input logic e);
      int n;
      n = 0;
      notes.push_back('{w ? 32'h0 : d, w ? 32'h0 : m, e});
      @(posedge mclk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge mclk);
      apb_req.penable <= 1'b1;
      do @(posedge mclk); while (apb_rsp.pready !== 1'b1 && ++n < 50);
      apb_req <= '0;
      // a missing answer counts against the run
      if (n >= 50) begin
         bad_count++;
         $display("mismatch at %0t: no pready", $time);
      end
   endtask
   // wait for k frame ticks and let the outputs settle
   task ticks(input int k);
      repeat (k) @(posedge mclk iff fp === 1'b1);
      repeat (2) @(posedge mclk);
   endtask
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // compare each answer with the oldest note
   always @(posedge mclk) begin
      smc_note_t n;
      if (apb_rsp.pready === 1'b1 && notes.size() > 0) begin
         n = notes.pop_front();
         n_tests++;
         if ((apb_rsp.prdata & n.m) !== (n.d & n.m) || apb_rsp.pslverr !== n.e) begin
            bad_count++;
            $display("mismatch at %0t: read %h err %b", $time, apb_rsp.prdata, apb_rsp.pslverr);
         end
      end
   end
   // cut a hang short
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      tally_and_finish();
   end
   // main sequence
   initial begin
      logic [9:0] s;
      logic [5:0] c;
      logic [1:0] dm;
      logic rs;
      void'($urandom(32'h7c0ddd44));
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      apb(1'b0, CTRL_OFS, {26'h0, CTRL_RST}, 32'h3f, 1'b0);
      for (int i = 0; i < 20; i++) begin
         s = STEPS[i];
         c = {2'($urandom), s[9:6]};
         // change losses and control just after a tick so no tick sees half of it
         @(posedge mclk iff fp === 1'b1);
         pri_cmd <= (c[1:0] == MS_AUTO) ? s[5] : 1'($urandom);
         sec_cmd <= (c[1:0] == MS_AUTO) ? s[4] : 1'($urandom);
         apb(1'b1, CTRL_OFS, {26'h0, c}, 32'h0, 1'b0);
         ticks(2);
         tiec += s[0];
         // dpll steering expected from the state code
         rs = (s[3:1] == 3'h2) || (s[3:1] == 3'h4);
         dm = (s[3:1] == 3'h0) ? DM_FREE : ((s[3:1] > 3'h2) ? DM_HOLD : DM_NORMAL);
         n_tests++;
         if (dpll_ctl.dpll_mode !== dm || dpll_ctl.ref_sel !== rs || dpll_ctl.freq_sel !== c[5:4]) begin
            bad_count++;
            $display("mismatch at %0t: mode %h ref %b", $time, dpll_ctl.dpll_mode, dpll_ctl.ref_sel);
         end
         apb(1'b0, STAT_OFS, {29'h0, s[3:1]}, 32'h27, 1'b0);
         apb(1'b0, TIEC_OFS, tiec, 32'hffffffff, 1'b0);
         apb(1'b0, CTRL_OFS, {26'h0, c}, 32'h3f, 1'b0);
         $display("step %0d done", i);
      end
      apb(1'b0, 8'h10, 32'h0, 32'hffffffff, 1'b1);
      apb(1'b1, STAT_OFS, 32'h7, 32'h0, 1'b0);
      apb(1'b0, STAT_OFS, 32'h1, 32'h7, 1'b0);
      word_a = $urandom;
      word_cmd <= word_a;
      ticks(500);
      word_cmd <= ~word_a;
      ticks(10);
      apb(1'b1, CTRL_OFS, 32'h1, 32'h0, 1'b0);
      ticks(2);
      apb(1'b0, HOLD_OFS, word_a, 32'hffffffff, 1'b0);
      $display("holdover store done");
      lock_dly <= 32'd200;
      apb(1'b1, CTRL_OFS, 32'h2, 32'h0, 1'b0);
      ticks(2);
      apb(1'b0, STAT_OFS, 32'h0, 32'h7, 1'b0);
      apb(1'b1, CTRL_OFS, 32'h0, 32'h0, 1'b0);
      ticks(8);
      apb(1'b0, STAT_OFS, 32'h21, 32'h27, 1'b0);
      $display("late lock done");
      tally_and_finish();
   end
endmodule
